// ---- core/oat_sys_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Per stage pulse or level enable, chosen channel
// R2: Level mode: rise turns on, low turns off
// R3: Event out shows warm or valid, chosen channel
// R4: Valid mode raises event when output valid
// R5: Enable-to-valid delay is start+warm+settle
// R6: Timer pulses one slow period at sample rate
// R7: Converter starts once per valid rising edge
// R8: Acquisition must end before enable falls
// R9: Conversion clock is converter clock over four
// R10: Acquisition lasts one conversion clock cycle
// R11: Conversion takes resolution plus one cycles
// R12: End of conversion pulse, one converter clock
// R13: Request after four samples at level three
// R14: Transfer drains FIFO while converting goes on
// R15: Any stage output selectable as converter input
// R16: Comparator inputs may pick stages 0, 1
// R17: Stages 2, 3 never reach the comparator
// R18: Comparator falling edge raises wake flag
// R19: Early enable fall: off, no valid event
module oat_sys_end
#(
   parameter int unsigned NCH = oat_pkg::NUM_CH,
   parameter int unsigned DW = oat_pkg::SAMPLE_W,
   parameter int unsigned PERIOD_CYC = oat_pkg::SAMPLE_PERIOD_CYC,
   parameter int unsigned PULSE_CYC = oat_pkg::TIMER_PULSE_CYC,
   parameter int unsigned FD = oat_pkg::FIFO_DEPTH,
   parameter int unsigned TCH = oat_pkg::TIMER_CH,
   parameter int unsigned TRIG_CH = oat_pkg::ADC_TRIG_CH
)
(
   input wire logic ref_clk,
   input wire logic rst,
   oat_evt_if.sys evt,
   input wire logic timer_run,
   input wire logic ram_wr_ready,
   input wire logic wake_clear,
   input wire logic err_clear,
   output var logic ram_wr_valid,
   output var logic [DW-1:0] ram_wr_data,
   output var logic adc_eoc_evt,
   output var logic dma_req,
   output var logic wake_irq,
   output var logic window_err,
   output var logic fifo_overflow,
   output var logic [$clog2(FD+1)-1:0] fifo_level
);
   localparam int unsigned TW = $clog2(PERIOD_CYC);
   localparam int unsigned DVW = $clog2(oat_pkg::ADC_CLK_DIV_CYC);
   localparam int unsigned PSW = $clog2(oat_pkg::ADC_CLOCK_PRESCALE_FIELD + 1);
   localparam int unsigned PHW = $clog2(oat_pkg::ADC_CONV_SAR_CYC + 1);
   localparam int unsigned AW = $clog2(FD);
   localparam int unsigned PW = $clog2(FD + 1);

   typedef struct packed {
      logic [TW-1:0] tmr;
      logic [NCH-1:0] en_ev;
      logic [DVW-1:0] div;
      logic [PSW-1:0] clock_prescale_field;
      oat_pkg::oat_adc_st_e adc_st;
      logic [PHW-1:0] ph;
      logic trig_prev;
      logic [DW-1:0] result;
      logic eoc;
      logic [FD-1:0][DW-1:0] fifo;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [PW-1:0] cnt;
      logic ovf;
      logic req;
      logic [PW-1:0] burst;
      logic out_v;
      logic [DW-1:0] out_d;
      logic sp_v;
      logic [DW-1:0] sp_d;
      logic cmp_prev;
      logic wake;
      logic werr;
   } oat_sys_s;

   oat_sys_s r;
   oat_sys_s n;

   logic adc_tick;
   logic sar_tick;
   logic trig;
   logic push;
   logic pop;
   logic take;
   logic cmp_hi;
   logic werr_set;
   logic ovf_set;

   always_comb
   begin
      n = r;
      // Enable pulse sits at the head of every sample period
      n.en_ev = '0;
      if (timer_run)
         n.tmr = (r.tmr == TW'(PERIOD_CYC - 1)) ? '0 : r.tmr + TW'(1);
      else
         n.tmr = '0;
      // Count 0 closes each period, so the first pulse after start is as long as the rest
      n.en_ev[TCH] = timer_run && (n.tmr != '0) && (n.tmr <= TW'(PULSE_CYC)); // [R6]

      // Converter clock and its prescaled conversion clock, restarted per trigger
      adc_tick = (r.div == DVW'(oat_pkg::ADC_CLK_DIV_CYC - 1));
      sar_tick = adc_tick && (r.clock_prescale_field == PSW'(oat_pkg::ADC_CLOCK_PRESCALE_FIELD)); // [R9]
      n.div = adc_tick ? '0 : r.div + DVW'(1);
      if (adc_tick)
         n.clock_prescale_field = (r.clock_prescale_field == PSW'(oat_pkg::ADC_CLOCK_PRESCALE_FIELD)) ? '0 : r.clock_prescale_field + PSW'(1); // [R9]
      trig = evt.stage_events[TRIG_CH] && !r.trig_prev;
      n.trig_prev = evt.stage_events[TRIG_CH];
      push = 1'h0;
      werr_set = 1'h0;
      ovf_set = 1'h0;
      case (r.adc_st)
         oat_pkg::ADC_IDLE:
         begin
            n.div = '0;
            n.clock_prescale_field = '0;
            n.ph = '0;
            if (trig)
               n.adc_st = oat_pkg::ADC_ACQ; // [R7]
         end
         oat_pkg::ADC_ACQ:
         begin
            if (!evt.stage_events[TRIG_CH])
               werr_set = 1'h1; // [R8]
            if (sar_tick)
            begin
               n.ph = r.ph + PHW'(1);
               if (n.ph == PHW'(oat_pkg::ADC_ACQ_SAR_CYC))
               begin
                  n.result = evt.adc_input; // [R10]
                  n.ph = '0;
                  n.adc_st = oat_pkg::ADC_CONV;
               end
            end
         end
         oat_pkg::ADC_CONV:
         begin
            if (sar_tick)
            begin
               n.ph = r.ph + PHW'(1);
               if (n.ph == PHW'(oat_pkg::ADC_CONV_SAR_CYC))
               begin
                  n.ph = '0;
                  n.adc_st = oat_pkg::ADC_EOC; // [R11]
                  push = 1'b1;
               end
            end
         end
         oat_pkg::ADC_EOC:
         begin
            if (adc_tick)
               n.adc_st = oat_pkg::ADC_IDLE; // [R12]
         end
         default: n.adc_st = oat_pkg::ADC_IDLE;
      endcase
      n.eoc = (n.adc_st == oat_pkg::ADC_EOC); // [R12]

      // A result with no room is dropped and flagged
      if (push && r.cnt == PW'(FD))
      begin
         ovf_set = 1'h1;
         push = 1'h0;
      end
      if (push)
      begin
         n.fifo[r.wp] = r.result;
         n.wp = (r.wp == AW'(FD - 1)) ? '0 : r.wp + AW'(1);
      end

      // Transfer side: a burst of valid level plus one words, stalled by the buffer
      pop = (r.burst != '0) && (r.cnt != '0) && !r.sp_v; // [R14]
      if (pop)
      begin
         n.rp = (r.rp == AW'(FD - 1)) ? '0 : r.rp + AW'(1);
         n.burst = r.burst - PW'(1);
      end
      else if (r.burst == '0 && r.req)
         n.burst = PW'(oat_pkg::FIFO_VALID_LEVEL + 1); // [R13]
      if (push && !pop)
         n.cnt = r.cnt + PW'(1);
      else if (pop && !push)
         n.cnt = r.cnt - PW'(1);
      n.req = (n.cnt > PW'(oat_pkg::FIFO_VALID_LEVEL)); // [R13]

      // Two-entry buffer toward memory; spare slot catches the word in flight
      take = r.out_v && ram_wr_ready;
      if (!r.out_v || take)
      begin
         if (r.sp_v)
         begin
            n.out_v = 1'b1;
            n.out_d = r.sp_d;
            n.sp_v = 1'b0;
         end
         else
         begin
            n.out_v = pop;
            n.out_d = pop ? r.fifo[r.rp] : r.out_d;
         end
      end
      else if (pop)
      begin
         n.sp_v = 1'b1;
         n.sp_d = r.fifo[r.rp];
      end

      // Sticky flags: a new event in the clearing cycle survives
      cmp_hi = (evt.cmp_pos_input >= evt.cmp_neg_input);
      n.cmp_prev = cmp_hi;
      n.wake = (r.wake && !wake_clear) || (r.cmp_prev && !cmp_hi); // [R18]
      n.werr = (r.werr && !err_clear) || werr_set; // [R8]
      n.ovf = (r.ovf && !err_clear) || ovf_set;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         r <= '0;
      else
         r <= n;
   end

   assign evt.enable_events = r.en_ev;
   assign ram_wr_valid = r.out_v;
   assign ram_wr_data = r.out_d;
   assign adc_eoc_evt = r.eoc;
   assign dma_req = r.req;
   assign wake_irq = r.wake;
   assign window_err = r.werr;
   assign fifo_overflow = r.ovf;
   assign fifo_level = r.cnt;
endmodule
`default_nettype wire

// ---- core/oat_pkg.sv ----
package oat_pkg;

   localparam int unsigned REF_CLK_MHZ = 20;
   localparam int unsigned REF_CLK_HZ = 20_000_000;
   localparam int unsigned NUM_STAGES = 4;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned SAMPLE_W = 12;

   // Enable pulse from the low energy timer: one slow clock period per sample
   localparam int unsigned TIMER_PULSE_NS = 30500;
   localparam int unsigned TIMER_PULSE_CYC = (TIMER_PULSE_NS * REF_CLK_MHZ) / 1000;
   localparam int unsigned SAMPLE_RATE_HZ = 16;
   localparam int unsigned SAMPLE_PERIOD_CYC = REF_CLK_HZ / SAMPLE_RATE_HZ;

   // Converter clocking and conversion lengths
   localparam int unsigned ADC_CLK_HZ = 4_000_000;
   localparam int unsigned ADC_CLK_DIV_CYC = REF_CLK_HZ / ADC_CLK_HZ;
   localparam int unsigned ADC_CLOCK_PRESCALE_FIELD = 3;
   localparam int unsigned ADC_ACQ_SAR_CYC = 1;
   localparam int unsigned ADC_RES_BITS = 12;
   localparam int unsigned ADC_CONV_SAR_CYC = ADC_RES_BITS + 1;
   localparam int unsigned FIFO_VALID_LEVEL = 3;
   localparam int unsigned FIFO_DEPTH = 4;

   // Amplifier sequencing intervals, least times rounded up
   localparam int unsigned START_DELAY_NS = 1000;
   localparam int unsigned WARMUP_NS = 5000;
   localparam int unsigned SETTLE_NS = 2000;
   localparam int unsigned START_DELAY_CYC = (START_DELAY_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int unsigned WARMUP_CYC = (WARMUP_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS * REF_CLK_MHZ + 999) / 1000;

   // Event channel assignment
   localparam int unsigned TIMER_CH = 1;
   localparam int unsigned ADC_TRIG_CH = 2;

   localparam logic EN_MODE_PULSE = 1'h0;
   localparam logic EN_MODE_LEVEL = 1'h1;
   localparam logic OUT_MODE_WARM = 1'h0;
   localparam logic OUT_MODE_VALID = 1'h1;

   localparam logic [2:0] ADC_SEL_STAGE0 = 3'h0;
   localparam logic [2:0] ADC_SEL_STAGE1 = 3'h1;
   localparam logic [2:0] ADC_SEL_STAGE2 = 3'h2;
   localparam logic [2:0] ADC_SEL_STAGE3 = 3'h3;
   localparam logic [2:0] ADC_SEL_DAC = 3'h4;
   localparam logic [1:0] CMP_SEL_STAGE0 = 2'h0;
   localparam logic [1:0] CMP_SEL_STAGE1 = 2'h1;
   localparam logic [1:0] CMP_SEL_DAC = 2'h2;
   localparam logic [1:0] CMP_SEL_EXT = 2'h3;

   typedef enum logic [2:0] {AMP_OFF, AMP_START, AMP_WARM, AMP_SETTLE, AMP_VALID} oat_amp_st_e;
   typedef enum logic [1:0] {ADC_IDLE, ADC_ACQ, ADC_CONV, ADC_EOC} oat_adc_st_e;

endpackage

// ---- core/oat_evt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface oat_evt_if
#(
   parameter int unsigned NCH = oat_pkg::NUM_CH,
   parameter int unsigned DW = oat_pkg::SAMPLE_W
);
   logic [NCH-1:0] enable_events;
   logic [NCH-1:0] stage_events;
   logic [DW-1:0] adc_input;
   logic [DW-1:0] cmp_pos_input;
   logic [DW-1:0] cmp_neg_input;

   modport amp
   (
      input enable_events,
      output stage_events,
      output adc_input,
      output cmp_pos_input,
      output cmp_neg_input
   );

   modport sys
   (
      output enable_events,
      input stage_events,
      input adc_input,
      input cmp_pos_input,
      input cmp_neg_input
   );
endinterface
`default_nettype wire

// ---- core/oat_amp_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module oat_amp_end
#(
   parameter int unsigned NS = oat_pkg::NUM_STAGES,
   parameter int unsigned NCH = oat_pkg::NUM_CH,
   parameter int unsigned DW = oat_pkg::SAMPLE_W,
   parameter int unsigned START_DLY_CYC = oat_pkg::START_DELAY_CYC,
   parameter int unsigned WARM_CYC = oat_pkg::WARMUP_CYC,
   parameter int unsigned SETTLE_CYC = oat_pkg::SETTLE_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst,
   oat_evt_if.amp evt,
   input wire logic [NS-1:0] enable_mode,
   input wire logic [NS-1:0][$clog2(NCH)-1:0] enable_ch_sel,
   input wire logic [NS-1:0] stage_off,
   input wire logic [NS-1:0] event_out_mode,
   input wire logic [NS-1:0] event_out_en,
   input wire logic [NS-1:0][$clog2(NCH)-1:0] event_out_ch_sel,
   input wire logic [2:0] adc_positive_input_select,
   input wire logic [1:0] cmp_positive_input_select,
   input wire logic [1:0] cmp_negative_input_select,
   input wire logic [NS-1:0][DW-1:0] stage_sample,
   input wire logic [DW-1:0] dac_sample,
   input wire logic [DW-1:0] ext_sample,
   output var logic [NS-1:0] stage_warm,
   output var logic [NS-1:0] stage_valid
);
   localparam logic [15:0] T_WARM = 16'(START_DLY_CYC);
   localparam logic [15:0] T_SETTLE = 16'(START_DLY_CYC + WARM_CYC);
   localparam logic [15:0] T_SUM = 16'(START_DLY_CYC + WARM_CYC + SETTLE_CYC);

   typedef struct packed {
      oat_pkg::oat_amp_st_e [NS-1:0] st;
      logic [NS-1:0][15:0] cnt;
      logic [NS-1:0] prev_in;
      logic [NCH-1:0] ev_out;
      logic [DW-1:0] adc_in;
      logic [DW-1:0] cmp_pos;
      logic [DW-1:0] cmp_neg;
      logic [NS-1:0] warm;
      logic [NS-1:0] valid;
   } oat_amp_s;

   oat_amp_s r;
   oat_amp_s n;

   // Phase follows from cycles elapsed since the enabling edge
   function automatic oat_pkg::oat_amp_st_e phase_of(input logic [15:0] c);
      if (c < T_WARM)
         return oat_pkg::AMP_START;
      else if (c < T_SETTLE)
         return oat_pkg::AMP_WARM;
      else if (c < T_SUM)
         return oat_pkg::AMP_SETTLE;
      else
         return oat_pkg::AMP_VALID; // [R5]
   endfunction

   // Only stages 0 and 1 have a path to the comparator
   function automatic logic [DW-1:0] cmp_pick(input logic [1:0] sel, input logic [DW-1:0] s0,
                                              input logic [DW-1:0] s1, input logic [DW-1:0] dac,
                                              input logic [DW-1:0] ext);
      case (sel)
         oat_pkg::CMP_SEL_STAGE0: return s0; // [R16]
         oat_pkg::CMP_SEL_STAGE1: return s1; // [R16]
         oat_pkg::CMP_SEL_DAC: return dac; // [R17]
         default: return ext;
      endcase
   endfunction

   always_comb
   begin
      n = r;
      n.ev_out = '0;
      for (int i = 0; i < NS; i++)
      begin
         n.prev_in[i] = evt.enable_events[enable_ch_sel[i]]; // [R1]
         case (r.st[i])
            oat_pkg::AMP_OFF:
            begin
               // The enabling edge counts as the first elapsed cycle
               if (evt.enable_events[enable_ch_sel[i]] && !r.prev_in[i])
               begin
                  n.cnt[i] = 16'h0001;
                  n.st[i] = phase_of(16'h0001); // [R2]
               end
            end
            default:
            begin
               if (r.cnt[i] != T_SUM)
                  n.cnt[i] = r.cnt[i] + 16'h0001;
               n.st[i] = phase_of(n.cnt[i]); // [R5]
            end
         endcase
         // Switch-off wins over progress, so a short level-mode enable never reaches valid
         if ((enable_mode[i] == oat_pkg::EN_MODE_LEVEL && !evt.enable_events[enable_ch_sel[i]]) ||
             (enable_mode[i] == oat_pkg::EN_MODE_PULSE && stage_off[i]))
         begin
            n.st[i] = oat_pkg::AMP_OFF; // [R2] [R19] [R8]
            n.cnt[i] = 16'h0000;
         end
         n.warm[i] = (n.st[i] == oat_pkg::AMP_SETTLE) || (n.st[i] == oat_pkg::AMP_VALID);
         n.valid[i] = (n.st[i] == oat_pkg::AMP_VALID); // [R4]
         if (event_out_en[i])
         begin
            n.ev_out[event_out_ch_sel[i]] = n.ev_out[event_out_ch_sel[i]] |
               ((event_out_mode[i] == oat_pkg::OUT_MODE_VALID) ? n.valid[i] : n.warm[i]); // [R3] [R4]
         end
      end
      case (adc_positive_input_select)
         oat_pkg::ADC_SEL_STAGE0: n.adc_in = stage_sample[0]; // [R15]
         oat_pkg::ADC_SEL_STAGE1: n.adc_in = stage_sample[1]; // [R15]
         oat_pkg::ADC_SEL_STAGE2: n.adc_in = stage_sample[2]; // [R15]
         oat_pkg::ADC_SEL_STAGE3: n.adc_in = stage_sample[3]; // [R15]
         oat_pkg::ADC_SEL_DAC: n.adc_in = dac_sample;
         default: n.adc_in = '0;
      endcase
      n.cmp_pos = cmp_pick(cmp_positive_input_select, stage_sample[0], stage_sample[1], dac_sample, ext_sample);
      n.cmp_neg = cmp_pick(cmp_negative_input_select, stage_sample[0], stage_sample[1], dac_sample, ext_sample);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         r <= '0;
      else
         r <= n;
   end

   assign evt.stage_events = r.ev_out;
   assign evt.adc_input = r.adc_in;
   assign evt.cmp_pos_input = r.cmp_pos;
   assign evt.cmp_neg_input = r.cmp_neg;
   assign stage_warm = r.warm;
   assign stage_valid = r.valid;
endmodule
`default_nettype wire

// ---- core/oat_sys_end_dummy_never.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- test/oat_link_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module oat_link_chk
#(
   parameter int PULSE = 300
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] enable_events,
   input wire logic [3:0] stage_events,
   input wire logic adc_eoc_evt,
   input wire logic dma_req,
   input wire logic [2:0] fifo_level,
   input wire logic window_err,
   input wire logic ram_wr_valid,
   input wire logic ram_wr_ready,
   input wire logic [11:0] ram_wr_data
);
   logic [15:0] hi_cnt_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Pulse is far too long for a repetition, so count it
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         hi_cnt_r <= 16'h0;
      else if (enable_events[1])
         hi_cnt_r <= hi_cnt_r + 16'h1;
      else
         hi_cnt_r <= 16'h0;
   end

   sequence valid_after_sum;
      ##159 !stage_events[2] ##1 stage_events[2];
   endsequence
   sequence warm_after_start;
      ##119 !stage_events[3] ##1 stage_events[3];
   endsequence
   sequence eoc_after_conv;
      ##280 !adc_eoc_evt ##1 adc_eoc_evt;
   endsequence
   sequence eoc_hold;
      adc_eoc_evt [*5] ##1 !adc_eoc_evt;
   endsequence

   a_valid_delay: assert property ($rose(enable_events[1]) |-> valid_after_sum)
      else $error("valid event off the start plus warm plus settle time");
   a_warm_delay: assert property ($rose(enable_events[1]) && !stage_events[3] |-> warm_after_start)
      else $error("warm event off the start plus warm time");
   a_level_off: assert property ($fell(enable_events[1]) |-> ##1 !stage_events[2])
      else $error("level gated stage still on after enable fell");
   a_eoc_delay: assert property ($rose(stage_events[2]) |-> eoc_after_conv)
      else $error("end of conversion not at acquire plus convert time");
   a_eoc_width: assert property ($rose(adc_eoc_evt) |-> eoc_hold)
      else $error("end of conversion pulse width wrong");
   a_acq_covered: assert property ($rose(stage_events[2]) |-> ##20 (stage_events[2] && !window_err))
      else $error("acquisition not covered by enable");
   a_dma_level: assert property (fifo_level >= 3'h4 |-> ##[0:1] dma_req)
      else $error("no transfer request at four samples");
   a_hold_word: assert property (ram_wr_valid && !ram_wr_ready |=> ram_wr_valid && $stable(ram_wr_data))
      else $error("stalled word not held");
   a_pulse_width: assert property ($fell(enable_events[1]) |-> hi_cnt_r == PULSE)
      else $error("timer pulse width wrong");
   a_quiet_chan: assert property ((enable_events & 4'hD) == 4'h0)
      else $error("timer drives a foreign channel");
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk, rst, timer_run, ram_wr_ready, wake_clear, err_clear;
   logic [3:0] en_mode, out_mode, out_en, stage_off, warm2, valid2;
   logic [3:0][1:0] en_ch, out_ch;
   logic [2:0] adc_sel;
   logic [1:0] pos_sel, neg_sel;
   logic [3:0][11:0] smp;
   logic [11:0] dac_smp, ext_smp, ram_wr_data;
   logic ram_wr_valid, adc_eoc_evt, dma_req, wake_irq, window_err, fifo_overflow, seen;
   logic [2:0] fifo_level;
   logic [11:0] adc_exp[5], cmp_exp[4], exp_q[$], got_q[$];
   int fail_count, cmp_count;

   oat_evt_if evt_if();
   oat_evt_if evt2_if();

   oat_amp_end oat_amp_end_inst (.ref_clk(ref_clk), .rst(rst), .evt(evt_if.amp), .enable_mode(en_mode),
      .enable_ch_sel(en_ch), .stage_off(stage_off), .event_out_mode(out_mode), .event_out_en(out_en),
      .event_out_ch_sel(out_ch), .adc_positive_input_select(adc_sel), .cmp_positive_input_select(pos_sel),
      .cmp_negative_input_select(neg_sel), .stage_sample(smp), .dac_sample(dac_smp), .ext_sample(ext_smp),
      .stage_warm(), .stage_valid());
   // Second end faces the bench so the enable can fall early on purpose
   oat_amp_end oat_amp_end_inst_b (.ref_clk(ref_clk), .rst(rst), .evt(evt2_if.amp), .enable_mode(en_mode),
      .enable_ch_sel(en_ch), .stage_off(stage_off), .event_out_mode(out_mode), .event_out_en(out_en),
      .event_out_ch_sel(out_ch), .adc_positive_input_select(adc_sel), .cmp_positive_input_select(pos_sel),
      .cmp_negative_input_select(neg_sel), .stage_sample(smp), .dac_sample(dac_smp), .ext_sample(ext_smp),
      .stage_warm(warm2), .stage_valid(valid2));
   oat_sys_end #(.PERIOD_CYC(800), .PULSE_CYC(300)) oat_sys_end_inst (.ref_clk(ref_clk), .rst(rst),
      .evt(evt_if.sys), .timer_run(timer_run), .ram_wr_ready(ram_wr_ready), .wake_clear(wake_clear),
      .err_clear(err_clear), .ram_wr_valid(ram_wr_valid), .ram_wr_data(ram_wr_data), .adc_eoc_evt(adc_eoc_evt),
      .dma_req(dma_req), .wake_irq(wake_irq), .window_err(window_err), .fifo_overflow(fifo_overflow),
      .fifo_level(fifo_level));
   oat_link_chk #(.PULSE(300)) oat_link_chk_inst (.ref_clk(ref_clk), .rst(rst),
      .enable_events(evt_if.enable_events), .stage_events(evt_if.stage_events), .adc_eoc_evt(adc_eoc_evt),
      .dma_req(dma_req), .fifo_level(fifo_level), .window_err(window_err), .ram_wr_valid(ram_wr_valid),
      .ram_wr_ready(ram_wr_ready), .ram_wr_data(ram_wr_data));

   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task check(input logic [11:0] got, input logic [11:0] exp, input string msg);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic wait_sig(ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (s !== 1'b1)
      begin
         fail_count++;
         $display("mismatch at %0t: wait ran out", $time);
         test_done();
      end
   endtask

   task pulse2(input int len);
      seen = 1'b0;
      @(posedge ref_clk);
      evt2_if.enable_events <= 4'h2;
      repeat (len) @(posedge ref_clk);
      #1;
      seen = valid2[0] && warm2[0];
      @(posedge ref_clk);
      evt2_if.enable_events <= 4'h0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
      if (!rst && ram_wr_valid === 1'b1 && ram_wr_ready === 1'b1)
         got_q.push_back(ram_wr_data);

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      $display("mismatch at %0t: run took too long", $time);
      test_done();
   end

   initial
   begin
      rst = 1'b1;
      timer_run = 1'b0;
      ram_wr_ready = 1'b0;
      wake_clear = 1'b0;
      err_clear = 1'b0;
      en_mode = 4'h1;
      out_mode = 4'h1;
      out_en = 4'h3;
      stage_off = 4'h0;
      en_ch = {2'h0, 2'h0, 2'h1, 2'h1};
      out_ch = {2'h0, 2'h0, 2'h3, 2'h2};
      adc_sel = 3'h0;
      pos_sel = 2'h0;
      neg_sel = 2'h0;
      smp = {12'h444, 12'h333, 12'h222, 12'h111};
      dac_smp = 12'h5A5;
      ext_smp = 12'h6C6;
      evt2_if.enable_events = 4'h0;
      adc_exp = '{12'h111, 12'h222, 12'h333, 12'h444, 12'h5A5};
      cmp_exp = '{12'h111, 12'h222, 12'h5A5, 12'h6C6};
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge ref_clk);
         adc_sel <= 3'(i);
         repeat (2) @(posedge ref_clk);
         #1;
         check(evt_if.adc_input, adc_exp[i], "converter input route");
      end
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         pos_sel <= 2'(i);
         neg_sel <= 2'(3 - i);
         repeat (2) @(posedge ref_clk);
         #1;
         check(evt_if.cmp_pos_input, cmp_exp[i], "comparator plus route");
         check(evt_if.cmp_neg_input, cmp_exp[3 - i], "comparator minus route");
      end
      $display("routing test done");
      @(posedge ref_clk);
      pos_sel <= 2'h0;
      neg_sel <= 2'h1;
      smp[0] <= 12'h300;
      repeat (4) @(posedge ref_clk);
      wake_clear <= 1'b1;
      @(posedge ref_clk);
      wake_clear <= 1'b0;
      smp[0] <= 12'h100;
      #1;
      check(12'(wake_irq), 12'h0, "wake flag not cleared");
      wait_sig(wake_irq, 8);
      @(posedge ref_clk);
      wake_clear <= 1'b1;
      @(posedge ref_clk);
      wake_clear <= 1'b0;
      #1;
      check(12'(wake_irq), 12'h0, "wake flag clear");
      $display("comparator test done");
      @(posedge ref_clk);
      adc_sel <= 3'h0;
      timer_run <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         @(posedge ref_clk);
         smp[0] <= 12'hA10 + 12'(k);
         exp_q.push_back(12'hA10 + 12'(k));
         wait_sig(adc_eoc_evt, 1000);
         check(12'(evt_if.stage_events[3]), 12'h1, "pulse mode stage dropped");
         repeat (6) @(posedge ref_clk);
      end
      timer_run <= 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      check(12'(ram_wr_valid), 12'h1, "stalled word missing");
      check(ram_wr_data, exp_q[0], "stalled word");
      @(posedge ref_clk);
      ram_wr_ready <= 1'b1;
      repeat (20) @(posedge ref_clk);
      check(12'(got_q.size()), 12'h4, "words delivered");
      foreach (got_q[i])
         check(got_q[i], exp_q[i], "delivered word");
      check(12'({window_err, fifo_overflow}), 12'h0, "error flags");
      stage_off[1] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      check(12'(evt_if.stage_events[3]), 12'h0, "pulse mode stage not held off");
      $display("stream test done");
      pulse2(100);
      check(12'({seen, evt2_if.stage_events[2]}), 12'h0, "early fall raised valid");
      // Well past the full sequence: a stage that kept running would be valid by now
      repeat (80) @(posedge ref_clk);
      #1;
      check(12'(valid2[0]), 12'h0, "valid after early fall");
      pulse2(200);
      check(12'(seen), 12'h1, "full pulse gave no valid");
      check(12'(evt2_if.stage_events[2]), 12'h0, "stage on after enable low");
      $display("early fall test done");
      @(posedge ref_clk);
      ram_wr_ready <= 1'b0;
      stage_off[1] <= 1'b0;
      timer_run <= 1'b1;
      // Seven results against four entries and a full buffer: the last one is dropped
      for (int k = 0; k < 7; k++)
      begin
         wait_sig(adc_eoc_evt, 1000);
         repeat (6) @(posedge ref_clk);
      end
      timer_run <= 1'b0;
      #1;
      check(12'({fifo_overflow, fifo_level}), 12'hC, "overflow with full fifo");
      check(12'(ram_wr_valid), 12'h1, "stalled word lost");
      @(posedge ref_clk);
      err_clear <= 1'b1;
      @(posedge ref_clk);
      err_clear <= 1'b0;
      #1;
      check(12'(fifo_overflow), 12'h0, "overflow flag clear");
      $display("overflow test done");
      test_done();
   end
endmodule
`default_nettype wire
